/* design/audio_dsp_control_port_i2c.sv */
/*
 Control-port front end: mode selection at reset, two-wire slave with
 subaddress decode and auto-increment, register file and safeload.
 Assumes rst is asynchronous active high, link_clk is a free running
 oversampling clock far faster than the bus clock, and open-drain wires
 are resolved outside from the output enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsp_ctrl_consts.svh"

// Operation
// (RULE_01) Boot low: two-wire; three latch lows: four-wire.
// (RULE_02) Boot high: fetch everything from external EEPROM.
// (RULE_03) Read and write every location, single or burst.
// (RULE_04) Address byte, two subaddress bytes, then data.
// (RULE_05) Decode word width, advance after that many bytes.
// (RULE_06) Core-run bit at 2076 halts and restarts core.
// (RULE_07) Safeload set moves into program within frame.
// (RULE_08) Self-boot drives clock, writeback input, guard output.
// (RULE_09) Two-wire mode is slave only, never initiates.
// (RULE_10) Address is 01101 plus two strap pins.
// (RULE_11) Address byte LSB: one reads, zero writes.
// (RULE_12) Eight address bits, acknowledge on ninth or idle.
// (RULE_13) Transfer runs until SDA rises with SCL high.
// (RULE_14) Master writes subaddress, repeated start, then reads.
// (RULE_15) Burst write advances subaddress at word boundary.
// (RULE_16) Start or stop out of sequence returns idle.
// (RULE_17) Master issues one start/stop per SCL high.
// (RULE_18) Invalid subaddress gets no acknowledge, then idle.
// (RULE_19) Read past top repeats top until master NACKs.
// (RULE_20) Write past top: discard, NACK, go idle.
// (RULE_21) Subaddress is 12 bits, upper four zero.
// (RULE_22) Four-wire mode holds until full reset.
// (RULE_23) Master acknowledges each byte it reads but the last.
// (RULE_24) Boot pin sampled only at reset release.
// (RULE_25) Release SDA after acknowledge and sent bytes.
module audio_dsp_control_port_i2c #(
	parameter int MEM_DEPTH     = 64,
	parameter int BOOT_SCL_HALF = `BOOT_SCL_HALF_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       link_clk,
	input  wire logic       boot_source_select,
	input  wire logic       strap_bit_low,
	input  wire logic       strap_bit_high,
	input  wire logic       scl_line,
	output logic            scl_drive,
	output logic            scl_oe_n,
	input  wire logic       sda_line,
	output logic            sda_drive,
	output logic            sda_oe_n,
	input  wire logic       latch_or_eeprom_guard,
	output logic            guard_drive,
	output logic            guard_oe_n,
	input  wire logic       audio_frame,
	input  wire logic       boot_done,
	input  wire logic       eeprom_write_enable,
	output logic            core_running,
	output logic [1:0]      dac_init_field,
	output logic            two_wire_mode,
	output logic            four_wire_mode,
	output logic            self_boot_mode,
	output logic            boot_fetch,
	output logic            writeback_trigger
);

	localparam int AW = $clog2(MEM_DEPTH);
	localparam logic [11:0] MEM_END = 12'(MEM_DEPTH);

	generate
		if (MEM_DEPTH < 2 || MEM_DEPTH > 2048)
		begin : g_bad_depth
			$error("MEM_DEPTH must lie in 2 to 2048");
		end
		if (BOOT_SCL_HALF < 1 || BOOT_SCL_HALF > 65535)
		begin : g_bad_half
			$error("BOOT_SCL_HALF must lie in 1 to 65535");
		end
	endgenerate

	function automatic logic sub_valid(input logic [11:0] s);
		sub_valid = (s < MEM_END) || (s == `SUB_CORE_CTL) ||
			(s == `SUB_DAC_SETUP) ||
			(s >= `SUB_SL_DATA && s < `SUB_SL_END);
	endfunction : sub_valid

	function automatic logic [2:0] sub_width(input logic [11:0] s);
		if ((s >= `SUB_SL_ADDR && s < `SUB_SL_END) ||
			s == `SUB_CORE_CTL || s == `SUB_DAC_SETUP)
			sub_width = `WIDTH_REG;
		else
			sub_width = `WIDTH_WORD;
	endfunction : sub_width

	// Clock domain: mode selection, self-boot pins, core outputs.
	dsp_ctrl_pkg::ctrl_mode_t mode;
	logic [2:0]  c_meta;
	logic [2:0]  c_sync;
	logic [1:0]  c_prev;
	logic [2:0]  r_meta;
	logic [2:0]  r_sync;
	logic [1:0]  cap_cnt;
	logic [1:0]  latch_cnt;
	logic [15:0] div_cnt;
	logic        frame_tog;
	logic        latch_fall;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			c_meta <= 3'h0;
			c_sync <= 3'h0;
			c_prev <= 2'h0;
		end
		else
		begin
			c_meta <= {strap_bit_high, latch_or_eeprom_guard,
				boot_source_select};
			c_sync <= c_meta;
			c_prev <= c_sync[2:1];
		end
	end

	assign latch_fall = c_prev[0] & ~c_sync[1];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode      <= dsp_ctrl_pkg::MODE_WAIT;
			cap_cnt   <= 2'h0;
			latch_cnt <= 2'h0;
		end
		else
		begin
			unique case (mode)
				dsp_ctrl_pkg::MODE_WAIT:
				begin
					// The strap is read only once the synchroniser holds it.
					cap_cnt <= cap_cnt + 2'h1;
					if (cap_cnt == 2'h2)
						mode <= c_sync[0] ? dsp_ctrl_pkg::MODE_BOOT :
							dsp_ctrl_pkg::MODE_TWO; // see RULE_24 RULE_01 RULE_02
				end
				dsp_ctrl_pkg::MODE_TWO:
					if (latch_fall)
					begin
						latch_cnt <= latch_cnt + 2'h1;
						if (latch_cnt == `SPI_LATCH_PULSES - 2'h1)
							mode <= dsp_ctrl_pkg::MODE_FOUR; // see RULE_01
					end
				dsp_ctrl_pkg::MODE_FOUR:
					mode <= dsp_ctrl_pkg::MODE_FOUR; // see RULE_22
				dsp_ctrl_pkg::MODE_BOOT:
					mode <= dsp_ctrl_pkg::MODE_BOOT; // see RULE_24
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			boot_fetch        <= 1'b0;
			div_cnt           <= 16'h0000;
			scl_drive         <= 1'b1;
			scl_oe_n          <= 1'b1;
			guard_oe_n        <= 1'b1;
			writeback_trigger <= 1'b0;
		end
		else
		begin
			boot_fetch <= (mode == dsp_ctrl_pkg::MODE_WAIT && cap_cnt ==
				2'h2 && c_sync[0]) || (boot_fetch && !boot_done); // see RULE_02
			// Only self-boot ever drives the clock pin. see RULE_08 RULE_09
			scl_oe_n <= (mode != dsp_ctrl_pkg::MODE_BOOT);
			if (boot_fetch && div_cnt == 16'(BOOT_SCL_HALF - 1))
			begin
				div_cnt   <= 16'h0000;
				scl_drive <= ~scl_drive;
			end
			else if (boot_fetch)
				div_cnt <= div_cnt + 16'h0001;
			else
				scl_drive <= 1'b1;
			guard_oe_n <= !(mode == dsp_ctrl_pkg::MODE_BOOT &&
				eeprom_write_enable); // see RULE_08
			writeback_trigger <= (mode == dsp_ctrl_pkg::MODE_BOOT) &&
				c_sync[2] && !c_prev[1]; // see RULE_08
		end
	end

	assign guard_drive = 1'b0;
	assign sda_drive   = 1'b0;
	assign two_wire_mode  = mode[1];
	assign four_wire_mode = mode[2];
	assign self_boot_mode = mode[3];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			frame_tog <= 1'b0;
		else if (audio_frame)
			frame_tog <= ~frame_tog;
	end

	// Link domain: oversampled bus, register file, safeload.
	dsp_ctrl_pkg::link_state_t state;
	logic [1:0]  lrst_sync;
	logic        link_rst;
	logic [5:0]  in_meta;
	logic [5:0]  in_sync;
	logic [2:0]  in_prev;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic        rw;
	logic [11:0] sub;
	logic [2:0]  byteidx;
	logic [39:0] wbuf;
	logic        drive_low;
	logic        mack;
	logic        tx_load;
	logic        sl_pend;
	logic [31:0] param_ram [MEM_DEPTH];
	logic [31:0] sl_data [`SL_COUNT];
	logic [11:0] sl_addr [`SL_COUNT];
	logic [15:0] core_ctl;
	logic [15:0] dac_setup;
	logic [39:0] rd_word;
	logic [7:0]  tx_byte;
	logic [5:0]  tx_shift;
	logic [39:0] new_word;
	logic [2:0]  idx_d;
	logic [2:0]  idx_a;
	logic        rise;
	logic        fall;
	logic        start_c;
	logic        stop_c;
	logic        tw_active;
	logic        addr_hit;
	logic        word_end;
	logic        word_done;
	logic        frame_evt;
	logic        sl_go;

	// Reset leaves the link domain only on a link clock edge.
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			lrst_sync <= 2'h0;
		else
			lrst_sync <= {lrst_sync[0], 1'b1};
	end

	assign link_rst = ~lrst_sync[1];

	always_ff @(posedge link_clk or posedge link_rst)
	begin
		if (link_rst)
		begin
			in_meta <= 6'h03;
			in_sync <= 6'h03;
			in_prev <= 3'h3;
		end
		else
		begin
			in_meta <= {mode[1], frame_tog, strap_bit_low, strap_bit_high,
				sda_line, scl_line};
			in_sync <= in_meta;
			in_prev <= {in_sync[4], in_sync[1:0]};
		end
	end

	assign tw_active = in_sync[5];
	assign rise      = in_sync[0] & ~in_prev[0];
	assign fall      = ~in_sync[0] & in_prev[0];
	// Both edges are judged with SCL high on two samples. see RULE_16 RULE_17
	assign start_c   = in_sync[0] & in_prev[0] & in_prev[1] & ~in_sync[1];
	assign stop_c    = in_sync[0] & in_prev[0] & ~in_prev[1] & in_sync[1];
	assign frame_evt = in_sync[4] ^ in_prev[2];
	assign addr_hit  = shreg[7:1] == {`SLAVE_ADDR_FIXED, in_sync[2],
		in_sync[3]}; // see RULE_10
	assign word_end  = byteidx == sub_width(sub) - 3'h1; // see RULE_05
	assign new_word  = {wbuf[31:0], shreg};
	assign word_done = tw_active && fall && bitcnt == 4'h8 && word_end &&
		state == dsp_ctrl_pkg::ST_WDATA && sub_valid(sub);
	assign idx_d     = 3'(sub - `SUB_SL_DATA);
	assign idx_a     = 3'(sub - `SUB_SL_ADDR);
	// A safeload waits one cycle if a bus word lands at the same time.
	assign sl_go     = sl_pend & ~word_done; // see RULE_07

	always_comb
	begin
		rd_word = 40'h00_0000_0000;
		if (sub < MEM_END)
			rd_word = {8'h00, param_ram[sub[AW-1:0]]};
		else if (sub >= `SUB_SL_DATA && sub < `SUB_SL_ADDR)
			rd_word = {8'h00, sl_data[idx_d]};
		else if (sub >= `SUB_SL_ADDR && sub < `SUB_SL_END)
			rd_word = {28'h000_0000, sl_addr[idx_a]};
		else if (sub == `SUB_CORE_CTL)
			rd_word = {24'h00_0000, core_ctl};
		else if (sub == `SUB_DAC_SETUP)
			rd_word = {24'h00_0000, dac_setup};
	end

	// Words go out most significant byte first. see RULE_03
	assign tx_shift = {3'(sub_width(sub) - 3'h1 - byteidx), 3'h0};
	assign tx_byte  = 8'(rd_word >> tx_shift);
	assign sda_oe_n = ~drive_low;

	always_ff @(posedge link_clk or posedge link_rst)
	begin
		if (link_rst)
		begin
			state     <= dsp_ctrl_pkg::ST_IDLE;
			bitcnt    <= 4'h0;
			shreg     <= 8'h00;
			rw        <= 1'b0;
			sub       <= 12'h000;
			byteidx   <= 3'h0;
			wbuf      <= 40'h00_0000_0000;
			drive_low <= 1'b0;
			mack      <= 1'b0;
			tx_load   <= 1'b0;
		end
		else if (!tw_active || stop_c)
		begin
			state     <= dsp_ctrl_pkg::ST_IDLE; // see RULE_13 RULE_16
			drive_low <= 1'b0;
			tx_load   <= 1'b0;
		end
		else if (start_c)
		begin
			state     <= dsp_ctrl_pkg::ST_ADDR; // see RULE_16 RULE_14
			bitcnt    <= 4'h0;
			drive_low <= 1'b0;
			tx_load   <= 1'b0;
		end
		else if (state != dsp_ctrl_pkg::ST_IDLE)
		begin
			if (tx_load)
			begin
				tx_load   <= 1'b0;
				drive_low <= ~tx_byte[7];
			end
			if (rise)
			begin
				bitcnt <= bitcnt + 4'h1;
				shreg  <= {shreg[6:0], in_sync[1]}; // see RULE_12 RULE_04
				if (state == dsp_ctrl_pkg::ST_RDATA && bitcnt == 4'h8)
					mack <= ~in_sync[1]; // see RULE_23
			end
			if (fall && bitcnt == 4'h8)
			begin
				unique case (state)
					dsp_ctrl_pkg::ST_IDLE:
						state <= dsp_ctrl_pkg::ST_IDLE;
					dsp_ctrl_pkg::ST_ADDR:
						if (addr_hit)
						begin
							drive_low <= 1'b1; // see RULE_12
							rw        <= shreg[0]; // see RULE_11
							byteidx   <= 3'h0;
						end
						else
							state <= dsp_ctrl_pkg::ST_IDLE; // see RULE_12
					dsp_ctrl_pkg::ST_SUB_HI:
						if (shreg[7:4] == 4'h0)
						begin
							drive_low  <= 1'b1;
							sub[11:8]  <= shreg[3:0]; // see RULE_21
						end
						else
							state <= dsp_ctrl_pkg::ST_IDLE; // see RULE_18
					dsp_ctrl_pkg::ST_SUB_LO:
						if (sub_valid({sub[11:8], shreg}))
						begin
							drive_low <= 1'b1;
							sub[7:0]  <= shreg;
							byteidx   <= 3'h0;
						end
						else
							state <= dsp_ctrl_pkg::ST_IDLE; // see RULE_18
					dsp_ctrl_pkg::ST_WDATA:
						if (sub_valid(sub))
						begin
							drive_low <= 1'b1;
							wbuf      <= new_word;
							byteidx   <= word_end ? 3'h0 : byteidx + 3'h1;
							if (word_end)
								sub <= sub + 12'h001; // see RULE_15 RULE_05
						end
						else
							state <= dsp_ctrl_pkg::ST_IDLE; // see RULE_20
					dsp_ctrl_pkg::ST_RDATA:
						drive_low <= 1'b0; // see RULE_25
				endcase
			end
			if (fall && bitcnt == 4'h9)
			begin
				bitcnt    <= 4'h0;
				drive_low <= 1'b0; // see RULE_25
				if (state == dsp_ctrl_pkg::ST_ADDR)
				begin
					state   <= rw ? dsp_ctrl_pkg::ST_RDATA :
						dsp_ctrl_pkg::ST_SUB_HI;
					tx_load <= rw;
				end
				else if (state == dsp_ctrl_pkg::ST_SUB_HI)
					state <= dsp_ctrl_pkg::ST_SUB_LO;
				else if (state == dsp_ctrl_pkg::ST_SUB_LO)
					state <= dsp_ctrl_pkg::ST_WDATA; // see RULE_04
				else if (state == dsp_ctrl_pkg::ST_RDATA && !mack)
					state <= dsp_ctrl_pkg::ST_IDLE; // see RULE_19
				else if (state == dsp_ctrl_pkg::ST_RDATA)
				begin
					tx_load <= 1'b1;
					byteidx <= word_end ? 3'h0 : byteidx + 3'h1;
					// The top location repeats instead of wrapping.
					if (word_end && sub_valid(sub + 12'h001))
						sub <= sub + 12'h001; // see RULE_19 RULE_03
				end
			end
			if (fall && state == dsp_ctrl_pkg::ST_RDATA &&
				bitcnt != 4'h0 && bitcnt < 4'h8)
				drive_low <= ~tx_byte[3'(4'h7 - bitcnt)];
		end
	end

	// Memory has no reset; software loads it before the core runs.
	always_ff @(posedge link_clk)
	begin
		if (sl_go)
		begin
			for (int i = 0; i < `SL_COUNT; i++)
				if (sl_addr[i] < MEM_END)
					param_ram[sl_addr[i][AW-1:0]] <= sl_data[i]; // see RULE_07
		end
		else if (word_done && sub < MEM_END)
			param_ram[sub[AW-1:0]] <= new_word[31:0]; // see RULE_03
	end

	always_ff @(posedge link_clk or posedge link_rst)
	begin
		if (link_rst)
		begin
			for (int i = 0; i < `SL_COUNT; i++)
			begin
				sl_data[i] <= 32'h0000_0000;
				sl_addr[i] <= 12'h000;
			end
			core_ctl  <= `CORE_CTL_RESET;
			dac_setup <= `DAC_SETUP_RESET;
			sl_pend   <= 1'b0;
		end
		else
		begin
			if (word_done && sub >= `SUB_SL_DATA && sub < `SUB_SL_ADDR)
				sl_data[idx_d] <= new_word[31:0];
			if (word_done && sub >= `SUB_SL_ADDR && sub < `SUB_SL_END)
				sl_addr[idx_a] <= new_word[11:0];
			if (word_done && sub == `SUB_CORE_CTL)
				core_ctl <= new_word[15:0]; // see RULE_06
			else if (sl_go)
				core_ctl[`CTL_SAFELOAD_BIT] <= 1'b0;
			if (word_done && sub == `SUB_DAC_SETUP)
				dac_setup <= new_word[15:0];
			if (frame_evt && core_ctl[`CTL_SAFELOAD_BIT])
				sl_pend <= 1'b1;
			else if (sl_go)
				sl_pend <= 1'b0;
		end
	end

	// Static control levels; the field settles before software relies on it.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r_meta         <= 3'h0;
			r_sync         <= 3'h0;
			core_running   <= 1'b0;
			dac_init_field <= 2'h0;
		end
		else
		begin
			r_meta <= {dac_setup[`DAC_INIT_LSB +: 2], core_ctl[`CTL_RUN_BIT]};
			r_sync <= r_meta;
			core_running   <= r_sync[0]; // see RULE_06
			dac_init_field <= r_sync[2:1];
		end
	end

	property p_slave_only;
		@(posedge clk) disable iff (rst)
		mode == dsp_ctrl_pkg::MODE_TWO |-> scl_oe_n;
	endproperty
	a_slave_only: assert property (p_slave_only) // see RULE_09
		else $error("clock pin driven in two-wire mode");

	property p_spi_entry;
		@(posedge clk) disable iff (rst)
		(mode == dsp_ctrl_pkg::MODE_TWO && latch_fall && latch_cnt == 2'h2)
		|=> mode == dsp_ctrl_pkg::MODE_FOUR;
	endproperty
	a_spi_entry: assert property (p_spi_entry) // see RULE_01
		else $error("third latch low did not enter four-wire mode");

	property p_spi_hold;
		@(posedge clk) disable iff (rst)
		mode == dsp_ctrl_pkg::MODE_FOUR |=> mode == dsp_ctrl_pkg::MODE_FOUR [*8];
	endproperty
	a_spi_hold: assert property (p_spi_hold) // see RULE_22
		else $error("four-wire mode left without reset");

	property p_mode_held;
		@(posedge clk) disable iff (rst)
		(mode != dsp_ctrl_pkg::MODE_WAIT && $changed(c_sync[0]))
		|=> (mode == $past(mode) || mode == dsp_ctrl_pkg::MODE_FOUR);
	endproperty
	a_mode_held: assert property (p_mode_held) // see RULE_24
		else $error("boot pin change altered the control mode");

	property p_boot_clock;
		@(posedge clk) disable iff (rst)
		(mode == dsp_ctrl_pkg::MODE_BOOT && boot_fetch) |=> !scl_oe_n;
	endproperty
	a_boot_clock: assert property (p_boot_clock) // see RULE_08
		else $error("clock pin not driven during self-boot fetch");

	property p_stop_idle;
		@(posedge link_clk) disable iff (link_rst)
		stop_c |=> state == dsp_ctrl_pkg::ST_IDLE && !drive_low;
	endproperty
	a_stop_idle: assert property (p_stop_idle) // see RULE_13
		else $error("stop did not return the link to idle");

	property p_start_addr;
		@(posedge link_clk) disable iff (link_rst)
		(start_c && tw_active) |=> state == dsp_ctrl_pkg::ST_ADDR &&
			bitcnt == 4'h0;
	endproperty
	a_start_addr: assert property (p_start_addr) // see RULE_16
		else $error("start did not restart address phase");

	property p_addr_ack;
		@(posedge link_clk) disable iff (link_rst)
		(tw_active && !stop_c && !start_c && fall && bitcnt == 4'h8 &&
			state == dsp_ctrl_pkg::ST_ADDR) |=> drive_low == $past(addr_hit);
	endproperty
	a_addr_ack: assert property (p_addr_ack) // see RULE_12
		else $error("address acknowledge does not follow match");

	property p_write_past_top;
		@(posedge link_clk) disable iff (link_rst)
		(tw_active && fall && bitcnt == 4'h8 && !sub_valid(sub) &&
			state == dsp_ctrl_pkg::ST_WDATA)
		|=> state == dsp_ctrl_pkg::ST_IDLE && !drive_low;
	endproperty
	a_write_past_top: assert property (p_write_past_top) // see RULE_20
		else $error("byte beyond top was acknowledged");

	property p_read_top;
		@(posedge link_clk) disable iff (link_rst)
		(state == dsp_ctrl_pkg::ST_RDATA && sub == `SUB_TOP) |=>
			sub == `SUB_TOP;
	endproperty
	a_read_top: assert property (p_read_top) // see RULE_19
		else $error("read ran past the top location");

	property p_safeload;
		@(posedge link_clk) disable iff (link_rst)
		(sl_pend && !word_done) |=> !sl_pend &&
			!core_ctl[`CTL_SAFELOAD_BIT];
	endproperty
	a_safeload: assert property (p_safeload) // see RULE_07
		else $error("safeload transfer not completed");

endmodule : audio_dsp_control_port_i2c
`default_nettype wire

/* inc/dsp_ctrl_consts.svh */
/*
 Constants of the control-port front end: subaddress map, field positions,
 reset values, word widths and timing counts.
 Assumes it is included by bare name from the design file.
*/
`ifndef DSP_CTRL_CONSTS_SVH
`define DSP_CTRL_CONSTS_SVH

`define SLAVE_ADDR_FIXED   5'h0d
`define SUB_SL_DATA        12'h810
`define SUB_SL_ADDR        12'h815
`define SUB_SL_END         12'h81a
`define SUB_CORE_CTL       12'h81c
`define SUB_DAC_SETUP      12'h827
`define SUB_TOP            12'h827
`define SL_COUNT           5
`define CTL_RUN_BIT        2
`define CTL_SAFELOAD_BIT   5
`define DAC_INIT_LSB       0
`define CORE_CTL_RESET     16'h0000
`define DAC_SETUP_RESET    16'h0000
`define WIDTH_WORD         3'h4
`define WIDTH_REG          3'h2
`define SPI_LATCH_PULSES   2'h3
`define CLK_PERIOD_NS      5
`define BOOT_SCL_HALF_NS   1250
`define BOOT_SCL_HALF_CYC  (`BOOT_SCL_HALF_NS / `CLK_PERIOD_NS)

`endif

/* inc/dsp_ctrl_pkg.sv */
/*
 Types of the control-port front end: link state machine and control mode.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dsp_ctrl_pkg;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_ADDR   = 6'b00_0010,
		ST_SUB_HI = 6'b00_0100,
		ST_SUB_LO = 6'b00_1000,
		ST_WDATA  = 6'b01_0000,
		ST_RDATA  = 6'b10_0000
	} link_state_t;

	typedef enum logic [3:0] {
		MODE_WAIT = 4'b0001,
		MODE_TWO  = 4'b0010,
		MODE_FOUR = 4'b0100,
		MODE_BOOT = 4'b1000
	} ctrl_mode_t;

endpackage : dsp_ctrl_pkg

/* verif/i2c_master_model.sv */
/*
 Two-wire bus master model that drives the control port from outside.
 Assumes the bench resolves SCL and SDA as wired-AND with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic clk,
	input  wire logic sda_in,
	output logic      scl_m,
	output logic      sda_m
);
	logic [7:0] got;
	event       done;
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// SDA moves late in the low phase, after the slave has let go.
	// The low phase outlasts the slave's reaction to a falling SCL, so
	// its first read bit is settled before SCL rises; the run stays short.
	task automatic bit_io(input logic b, output logic r);
		wt(100);
		sda_m = b;
		wt(30);
		scl_m = 1'b1;
		wt(64);
		r = sda_in;
		wt(64);
		scl_m = 1'b0;
	endtask : bit_io
	task automatic start();
		wt(100);
		sda_m = 1'b1;
		wt(30);
		scl_m = 1'b1;
		wt(64);
		sda_m = 1'b0;
		wt(64);
		scl_m = 1'b0;
	endtask : start
	task automatic stop();
		wt(100);
		sda_m = 1'b0;
		wt(30);
		scl_m = 1'b1;
		wt(64);
		sda_m = 1'b1;
		wt(64);
	endtask : stop
	task automatic wr(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		got = {7'h00, r};
		->done;
	endtask : wr
	task automatic rd(input logic nk);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			got[i] = r;
		end
		bit_io(nk, r);
		->done;
	endtask : rd
endmodule : i2c_master_model
`default_nettype wire

/* verif/audio_dsp_control_port_i2c_tb.sv */
/*
 Bench for the control-port front end: bus master model, queued results.
 Assumes the design and the master model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module audio_dsp_control_port_i2c_tb;
	logic        clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst = 1'b1;
	logic        boot = 1'b0;
	logic        sbl, sbh, scl_m, sda_m, scl_drive, scl_oe_n;
	logic        sda_drive, sda_oe_n, guard_drive, guard_oe_n;
	logic        core_running, two_wire_mode, four_wire_mode;
	logic        self_boot_mode, boot_fetch, writeback_trigger;
	logic        latch_m = 1'b1;
	logic        done_in = 1'b0;
	logic        frame = 1'b0;
	logic        wr_en = 1'b0;
	logic [1:0]  dac_init_field;
	logic [31:0] r;
	logic [7:0]  adr;
	logic [7:0]  d[8];
	logic [15:0] exq[$];
	int          seed = 32'h0000_40c8;
	int          bad_count = 0;
	int          cmp_count = 0;
	wire         scl_w = scl_m & (scl_oe_n | scl_drive);
	wire         sda_w = sda_m & (sda_oe_n | sda_drive);
	wire         guard_w = latch_m & (guard_oe_n | guard_drive);
	always #2.5 clk = ~clk;
	initial
	begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	audio_dsp_control_port_i2c #(.BOOT_SCL_HALF(4)) dut (
		.clk(clk), .rst(rst), .link_clk(link_clk),
		.boot_source_select(boot), .strap_bit_low(sbl),
		.strap_bit_high(sbh), .scl_line(scl_w), .scl_drive(scl_drive),
		.scl_oe_n(scl_oe_n), .sda_line(sda_w), .sda_drive(sda_drive),
		.sda_oe_n(sda_oe_n), .latch_or_eeprom_guard(guard_w),
		.guard_drive(guard_drive), .guard_oe_n(guard_oe_n),
		.audio_frame(frame), .boot_done(done_in),
		.eeprom_write_enable(wr_en), .core_running(core_running),
		.dac_init_field(dac_init_field), .two_wire_mode(two_wire_mode),
		.four_wire_mode(four_wire_mode), .self_boot_mode(self_boot_mode),
		.boot_fetch(boot_fetch), .writeback_trigger(writeback_trigger)
	);
	i2c_master_model m (.clk(clk), .sda_in(sda_w), .scl_m(scl_m),
		.sda_m(sda_m));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	always @(m.done)
	begin
		chk(exq.size() > 0 ? exq.pop_front() : 16'hdead, {8'h00, m.got});
	end
	task automatic till(ref logic s, input logic v);
		for (int i = 0; i < 40 && s !== v; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk({15'h0000, v}, {15'h0000, s});
		if (s !== v)
			stop_test();
	endtask : till
	task automatic wb(input logic [7:0] b, input logic nk);
		exq.push_back({15'h0000, nk});
		m.wr(b);
	endtask : wb
	task automatic rb(input logic [7:0] b, input logic nk);
		exq.push_back({8'h00, b});
		m.rd(nk);
	endtask : rb
	task automatic hdr(input logic [15:0] s);
		m.start();
		wb(adr, 1'b0);
		wb(s[15:8], 1'b0);
		wb(s[7:0], 1'b0);
	endtask : hdr
	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(posedge link_clk);
		@(posedge clk);
		#1;
		rst = 1'b0;
		repeat (300) @(posedge clk);
		#1;
	endtask : do_reset
	task automatic mode(input logic [15:0] e);
		chk(e, {13'h0000, two_wire_mode, four_wire_mode, self_boot_mode});
	endtask : mode
	initial
	begin
		#640_000;
		bad_count++;
		stop_test();
	end
	initial
	begin
		r = $random(seed);
		sbl = r[0];
		sbh = r[1];
		adr = {5'h0d, r[1], r[0], 1'b0};
		do_reset();
		mode(16'h0004);
		hdr(16'h081c);
		wb(8'h00, 1'b0);
		wb(8'h24, 1'b0);
		m.stop();
		till(core_running, 1'b1);
		frame = 1'b1;
		@(posedge clk);
		#1;
		frame = 1'b0;
		repeat (300) @(posedge clk);
		#1;
		chk(16'h0001, {15'h0000, core_running});
		$display("test core run done");
		hdr(16'h003e);
		for (int i = 0; i < 8; i++)
		begin
			r = $random(seed);
			d[i] = r[7:0];
			wb(d[i], 1'b0);
		end
		m.stop();
		hdr(16'h003f);
		m.start();
		wb(adr | 8'h01, 1'b0);
		rb(d[4], 1'b0);
		rb(d[5], 1'b1);
		m.stop();
		$display("test burst done");
		m.start();
		wb(adr ^ 8'h02, 1'b1);
		m.stop();
		m.start();
		wb(adr, 1'b0);
		wb(8'h08, 1'b0);
		wb(8'h20, 1'b1);
		m.stop();
		hdr(16'h081c);
		wb(8'h00, 1'b0);
		m.stop();
		chk(16'h0001, {15'h0000, core_running});
		$display("test refusals done");
		hdr(16'h0827);
		wb(8'h00, 1'b0);
		wb(8'h01, 1'b0);
		wb(8'h55, 1'b1);
		m.stop();
		chk(16'h0001, {14'h0000, dac_init_field});
		hdr(16'h0827);
		m.start();
		wb(adr | 8'h01, 1'b0);
		for (int i = 0; i < 4; i++)
			rb(i[0] ? 8'h01 : 8'h00, i == 3);
		m.stop();
		$display("test top done");
		for (int i = 0; i < 3; i++)
		begin
			latch_m = 1'b0;
			repeat (4) @(posedge clk);
			#1;
			latch_m = 1'b1;
			repeat (4) @(posedge clk);
			#1;
		end
		repeat (10) @(posedge clk);
		#1;
		mode(16'h0002);
		m.start();
		wb(adr, 1'b1);
		m.stop();
		mode(16'h0002);
		$display("test four wire done");
		boot = 1'b1;
		do_reset();
		mode(16'h0001);
		chk(16'h0001, {15'h0000, boot_fetch});
		chk(16'h0000, {15'h0000, scl_oe_n});
		till(scl_drive, 1'b0);
		wr_en = 1'b1;
		sbh = ~sbh;
		@(posedge clk);
		#1;
		sbh = 1'b1;
		till(writeback_trigger, 1'b1);
		till(guard_oe_n, 1'b0);
		done_in = 1'b1;
		till(boot_fetch, 1'b0);
		till(scl_drive, 1'b1);
		$display("test self boot done");
		stop_test();
	end
endmodule : audio_dsp_control_port_i2c_tb
`default_nettype wire
